// File: core/adc_cmd_pkg.sv
// Function
// - chip select high keeps the shutdown mode chosen by the power field
// - chip select high keeps the serial output undriven
// - external reference: normal while selected, shutdown while deselected
// - chip select falling wakes analog section and lets SCLK shift commands in
// - acquisition and conversion start from SCLK edges, no start input
// - 8-bit words: output low until 8th SCLK fall, then result MSB first
// - 16-bit words: output low, result MSB first from 16th SCLK fall
// - result shifts out as unsigned straight binary, MSB first
// - DSP mode: frame-sync input pulse starts a conversion sequenced by SCLK
// - DSP mode: frame-sync output pulse marks result ready on serial output
// - width-select input chooses 8-bit or 16-bit transfer words
// - 16-bit words stretch acquisition to eleven and a half SCLK cycles
// - three serial modes: external clock, internal clock, internal with scan
// - command: channel 7..5, scan 4..3, power 2..1, clock source 0
// - power-on reset sets power field bits, clears all others
// - channel field is a binary index of analog input 0 to 7
// - four-input scan: single, 0 to N, 2 to N, N four times
// - eight-input scan, internal clock only: 0 to N, 4 to N, N eight times
// - power codes: all on, all off, reference only, external reference
// - external or live reference needs no settling delay
// - width select low means 8-bit words, high means 16-bit words
// - selected power-down mode is entered on chip select rising edge
// - input bits latch on SCLK rises, from the first rise after select
package adc_cmd_pkg;
	localparam int CMD_W = 8;
	localparam int CH_HI = 7;
	localparam int CH_LO = 5;
	localparam int SCAN_HI = 4;
	localparam int SCAN_LO = 3;
	localparam int PD_HI = 2;
	localparam int PD_LO = 1;
	localparam int CLK_BIT = 0;
	localparam logic [7:0] CMD_RESET = 8'h06;
	localparam int RESULT_W = 14;
	localparam int WORD_W = 16;
	localparam int PAD_W = WORD_W - RESULT_W;
	// scan codes
	localparam logic [1:0] SCAN_SINGLE = 2'h0;
	localparam logic [1:0] SCAN_LOW = 2'h1;
	localparam logic [1:0] SCAN_UPPER = 2'h2;
	localparam logic [1:0] SCAN_REPEAT = 2'h3;
	// power-down codes
	localparam logic [1:0] PD_ALL_ON = 2'h0;
	localparam logic [1:0] PD_ALL_OFF = 2'h1;
	localparam logic [1:0] PD_REF_ONLY = 2'h2;
	localparam logic [1:0] PD_EXT_REF = 2'h3;
	// SCLK edge numbers of the externally clocked frame
	localparam logic [5:0] CH_RISE = 6'h03;
	localparam logic [5:0] CMD_RISE = 6'h08;
	localparam logic [5:0] SAMPLE_FALL_8 = 6'h06;
	localparam logic [5:0] SAMPLE_FALL_16 = 6'h0E;
	localparam logic [5:0] PRESENT_FALL_8 = 6'h08;
	localparam logic [5:0] PRESENT_FALL_16 = 6'h10;
	localparam logic [5:0] RISE_MAX = 6'h3F;
	// internal oscillator sequence in oscillator ticks; last readback bit in SCLK falls
	localparam logic [4:0] ACQ_TICKS = 5'h05;
	localparam logic [4:0] CONV_TICKS = 5'h10;
	localparam logic [3:0] LAST_BIT = 4'hF;
endpackage

// File: core/pin_sync.sv
// two-stage synchroniser for asynchronous pins; stage one feeds only stage two
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	// reset to the idle level of each pin
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= INIT;
			q_o <= INIT;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

// File: core/result_store.sv
// flop store for scan results, one write port and one read port
module result_store #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	// one entry per generate step
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge ref_clk_i or posedge rst_i) begin
			if (rst_i) begin
				mem[i] <= '0;
			end else if (we_i && waddr_i == AW'(i)) begin
				mem[i] <= wdata_i;
			end
		end
	end

	assign rdata_o = mem[raddr_i];
endmodule

// File: core/serial_adc_command_port.sv
module serial_adc_command_port import adc_cmd_pkg::*; #(
	parameter int OSC_DIV = 4,
	parameter logic [2:0] SCAN_MID = 3'h4,
	parameter logic [3:0] SCAN_TIMES = 4'h8
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic din_i,
	input wire logic frame_sync_in_i,
	input wire logic word_width_select_i,
	input wire logic [RESULT_W-1:0] sample_data_i,
	output logic dout_o,
	output logic dout_oe_o,
	output logic eoc_n_o,
	output logic frame_sync_out_o,
	output logic [2:0] channel_o,
	output logic sample_o,
	output logic analog_on_o,
	output logic ref_on_o,
	output logic buf_on_o,
	output logic osc_on_o
);
	typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_ACQ, ST_CONV, ST_DONE} conv_state_e;

	logic [4:0] pins;
	logic cs_d;
	logic sclk_d;
	logic fs_d;
	logic [5:0] rise_cnt;
	logic [6:0] shift_in;
	logic [7:0] cmd;
	logic [1:0] pd_held;
	logic dsp_mode;
	logic [RESULT_W-1:0] conv_sample;
	logic [WORD_W-1:0] dout_sr;
	logic int_read;
	logic [3:0] rd_bits;
	logic [2:0] rd_idx;
	conv_state_e state;
	logic [4:0] tick_cnt;
	logic [2:0] conv_idx;
	logic [$clog2(OSC_DIV+1)-1:0] osc_cnt;
	logic osc_tick;
	logic [RESULT_W-1:0] store_rdata;

	// every serial-port pin crosses two flops first; select and frame sync idle high
	pin_sync #(.WIDTH(5), .INIT(5'h12)) u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i({cs_n_i, sclk_i, din_i, frame_sync_in_i, word_width_select_i}),
		.q_o(pins)
	);

	wire cs_n_s = pins[4];
	wire sclk_s = pins[3];
	wire din_s = pins[2];
	wire fs_s = pins[1];
	wire wide_s = pins[0];
	wire active = ~cs_n_s;

	// edge detection on synchronised levels
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire cs_rise = cs_n_s & ~cs_d;
	wire fs_fall = ~fs_s & fs_d;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cs_d <= 1'b1;
			sclk_d <= 1'b0;
			fs_d <= 1'b1;
		end else begin
			cs_d <= cs_n_s;
			sclk_d <= sclk_s;
			fs_d <= fs_s;
		end
	end

	// command fields
	wire [2:0] cmd_ch = cmd[CH_HI:CH_LO];
	wire [1:0] cmd_scan = cmd[SCAN_HI:SCAN_LO];
	wire [1:0] cmd_pd = cmd[PD_HI:PD_LO];
	wire cmd_int_clk = cmd[CLK_BIT];
	wire [7:0] next_cmd = {shift_in, din_s};
	wire cmd_done = sclk_rise && rise_cnt == CMD_RISE - 6'h01;

	// SCLK rise counter restarts on select and on a frame-sync pulse
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rise_cnt <= '0;
		end else if (!active || fs_fall) begin
			rise_cnt <= '0;
		end else if (sclk_rise && rise_cnt != RISE_MAX) begin
			rise_cnt <= rise_cnt + 6'h01;
		end
	end

	// command bits enter on rises 1..8, MSB first
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_in <= '0;
		end else if (active && sclk_rise && rise_cnt < CMD_RISE) begin
			shift_in <= next_cmd[6:0];
		end
	end

	// register updates only as a whole on the 8th rise, so a cut frame changes nothing
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd <= CMD_RESET;
		end else if (active && cmd_done) begin
			cmd <= next_cmd;
		end
	end

	// power mode captured at deselect and held until the next select
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pd_held <= CMD_RESET[PD_HI:PD_LO];
		end else if (cs_rise) begin
			pd_held <= cmd_pd;
		end
	end

	// DSP mode is armed by a frame-sync pulse while externally clocked
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dsp_mode <= 1'b0;
		end else if (!active) begin
			dsp_mode <= 1'b0;
		end else if (fs_fall && !cmd_int_clk) begin
			dsp_mode <= 1'b1;
		end
	end

	// power outputs: selected means on, except that external reference keeps both off
	wire ref_want = active ? (cmd_pd != PD_EXT_REF) :
		(pd_held == PD_ALL_ON || pd_held == PD_REF_ONLY);
	wire buf_want = active ? (cmd_pd != PD_EXT_REF) : (pd_held == PD_ALL_ON);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			analog_on_o <= 1'b0;
			ref_on_o <= 1'b0;
			buf_on_o <= 1'b0;
		end else begin
			analog_on_o <= active;
			ref_on_o <= ref_want;
			buf_on_o <= buf_want;
		end
	end

	// scan plan from the stored command
	wire [2:0] upper_first = (cmd_ch >= SCAN_MID) ? SCAN_MID : cmd_ch;
	wire [3:0] upper_count = (cmd_ch >= SCAN_MID) ? {1'b0, cmd_ch - SCAN_MID} + 4'h1 : 4'h1;
	wire [2:0] first_ch = (cmd_scan == SCAN_LOW) ? 3'h0 :
		(cmd_scan == SCAN_UPPER) ? upper_first : cmd_ch;
	wire [3:0] conv_count = (cmd_scan == SCAN_LOW) ? {1'b0, cmd_ch} + 4'h1 :
		(cmd_scan == SCAN_UPPER) ? upper_count :
		(cmd_scan == SCAN_REPEAT) ? SCAN_TIMES : 4'h1;
	wire stepping = (cmd_scan == SCAN_LOW) || (cmd_scan == SCAN_UPPER);
	wire [2:0] conv_ch = stepping ? first_ch + conv_idx : cmd_ch;
	wire [2:0] next_scan_ch = stepping ? first_ch + conv_idx + 3'h1 : cmd_ch;
	wire more_conv = ({1'b0, conv_idx} + 4'h1) < conv_count;

	// external-clock frame edges depend on the word width
	wire [5:0] sample_fall = wide_s ? SAMPLE_FALL_16 : SAMPLE_FALL_8;
	wire [5:0] present_fall = wide_s ? PRESENT_FALL_16 : PRESENT_FALL_8;
	wire ext_sample = active && sclk_fall && rise_cnt == sample_fall;
	wire ext_load = active && sclk_fall && rise_cnt == present_fall && !cmd_int_clk;
	wire int_sample = state == ST_ACQ && osc_tick && tick_cnt == ACQ_TICKS - 5'h01;
	wire int_end = state == ST_CONV && osc_tick && tick_cnt == CONV_TICKS - 5'h01;

	// internal oscillator modelled by a divider enable
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_cnt <= '0;
			osc_tick <= 1'b0;
		end else if (state == ST_IDLE || state == ST_DONE) begin
			osc_cnt <= '0;
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= osc_cnt == ($bits(osc_cnt))'(OSC_DIV - 1);
			osc_cnt <= (osc_cnt == ($bits(osc_cnt))'(OSC_DIV - 1)) ? '0 : osc_cnt + 1'b1;
		end
	end

	// internal-clock sequence; deselect aborts it at once
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			tick_cnt <= '0;
			conv_idx <= '0;
		end else if (!active) begin
			state <= ST_IDLE;
			tick_cnt <= '0;
			conv_idx <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (cmd_done && next_cmd[CLK_BIT]) begin
						state <= ST_WAKE;
						conv_idx <= '0;
					end
				end
				ST_WAKE: begin
					if (osc_tick) begin
						state <= ST_ACQ;
						tick_cnt <= '0;
					end
				end
				ST_ACQ: begin
					if (int_sample) begin
						state <= ST_CONV;
						tick_cnt <= '0;
					end else if (osc_tick) begin
						tick_cnt <= tick_cnt + 5'h01;
					end
				end
				ST_CONV: begin
					if (int_end) begin
						state <= more_conv ? ST_ACQ : ST_DONE;
						conv_idx <= more_conv ? conv_idx + 3'h1 : conv_idx;
						tick_cnt <= '0;
					end else if (osc_tick) begin
						tick_cnt <= tick_cnt + 5'h01;
					end
				end
				ST_DONE: begin
					state <= ST_DONE;
				end
			endcase
		end
	end

	// channel follows the 3rd rise externally, the scan plan internally
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			channel_o <= '0;
		end else if (active && sclk_rise && rise_cnt == CH_RISE - 6'h01) begin
			channel_o <= next_cmd[2:0];
		end else if (state == ST_WAKE || (state == ST_CONV && int_end && more_conv)) begin
			// repeat mode keeps input N; only the stepping scans advance
			channel_o <= (state == ST_WAKE) ? first_ch : next_scan_ch;
		end else if (state == ST_ACQ) begin
			channel_o <= conv_ch;
		end
	end

	// hold strobe and captured sample
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			conv_sample <= '0;
			sample_o <= 1'b0;
		end else begin
			sample_o <= ext_sample || int_sample;
			if (ext_sample || int_sample) begin
				conv_sample <= sample_data_i;
			end
		end
	end

	// readback pointer looks one word ahead so the next entry is ready at word end
	wire word_end = int_read && rd_bits == LAST_BIT;
	wire [2:0] next_idx = word_end ? rd_idx + 3'h1 : rd_idx;
	wire next_ready = ({1'b0, rd_idx} + 4'h1) < conv_count;
	wire int_load = state == ST_DONE && !int_read;

	// results of a scan wait here until the host clocks them out
	result_store #(.WIDTH(RESULT_W), .DEPTH(8), .AW(3)) u_store (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.we_i(int_end),
		.waddr_i(conv_idx),
		.wdata_i(conv_sample),
		.raddr_i(next_idx),
		.rdata_o(store_rdata)
	);

	// output shifter: low until the result is presented, zeros after it
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dout_sr <= '0;
			int_read <= 1'b0;
			rd_bits <= '0;
			rd_idx <= '0;
		end else if (!active) begin
			dout_sr <= '0;
			int_read <= 1'b0;
			rd_bits <= '0;
			rd_idx <= '0;
		end else if (ext_load) begin
			dout_sr <= {conv_sample, PAD_W'(0)};
		end else if (int_load) begin
			dout_sr <= {store_rdata, PAD_W'(0)};
			int_read <= 1'b1;
		end else if (sclk_fall) begin
			rd_bits <= int_read ? rd_bits + 4'h1 : rd_bits;
			rd_idx <= (word_end && next_ready) ? next_idx : rd_idx;
			if (word_end && next_ready) begin
				dout_sr <= {store_rdata, PAD_W'(0)};
			end else begin
				dout_sr <= {dout_sr[WORD_W-2:0], 1'b0};
			end
		end
	end

	assign dout_o = dout_sr[WORD_W-1];

	// output drive, done flag and frame-sync notice
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dout_oe_o <= 1'b0;
			eoc_n_o <= 1'b1;
			frame_sync_out_o <= 1'b0;
			osc_on_o <= 1'b0;
		end else begin
			dout_oe_o <= active;
			eoc_n_o <= !(active && state == ST_DONE);
			frame_sync_out_o <= ext_load && dsp_mode;
			osc_on_o <= state != ST_IDLE && state != ST_DONE;
		end
	end
endmodule

// File: dv/adc_cmd_props.sv
module adc_cmd_props (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic dout_o,
	input wire logic dout_oe_o,
	input wire logic eoc_n_o,
	input wire logic frame_sync_out_o,
	input wire logic sample_o,
	input wire logic analog_on_o,
	input wire logic osc_on_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// six cycles covers the pin synchroniser plus the output register
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	a_oe_released: assert property (cs_n_i [*6] |-> !dout_oe_o)
		else $error("serial output driven while deselected");
	a_oe_on_select: assert property ($fell(cs_n_i) |-> ##[2:6] dout_oe_o)
		else $error("serial output not driven after select");
	a_dout_low_start: assert property ($rose(dout_oe_o) |-> !dout_o)
		else $error("serial output not low when first driven");
	a_analog_wake: assert property ($fell(cs_n_i) |-> ##[2:6] analog_on_o)
		else $error("analog section not woken by select");
	a_shutdown_idle: assert property (cs_n_i [*6] |-> !analog_on_o && !osc_on_o)
		else $error("analog or oscillator on while deselected");
	a_eoc_idle: assert property (cs_n_i [*6] |-> eoc_n_o)
		else $error("conversion done low while deselected");
	a_eoc_holds: assert property (!eoc_n_o && !cs_n_i && !$past(cs_n_i, 4) |=> !eoc_n_o)
		else $error("conversion done released while selected");
	a_osc_stops: assert property ($fell(eoc_n_o) |-> ##[0:2] !osc_on_o)
		else $error("oscillator still running after conversion done");
	a_fs_out_single: assert property (frame_sync_out_o |=> !frame_sync_out_o)
		else $error("frame sync output longer than one cycle");
	a_fs_out_driven: assert property (frame_sync_out_o |-> dout_oe_o)
		else $error("frame sync output while serial output released");
	a_sample_single: assert property (sample_o |=> !sample_o)
		else $error("hold pulse longer than one cycle");
	c_eoc: cover property ($fell(eoc_n_o));
	c_fs_out: cover property (frame_sync_out_o);
	c_sample: cover property (sample_o ##1 !sample_o);
endmodule

// File: dv/host_port_model.sv
module host_port_model #(
	parameter int SETTLE_NS = 5000000
) (
	input wire logic dout_i,
	input wire logic dout_oe_i,
	input wire logic eoc_n_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o,
	output logic fs_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [127:0] rx;
	int cyc;
	logic [1:0] last_pd = 2'h3;
	logic held;
	wire line = dout_oe_i ? dout_i : ~held;
	// a released output reads as the inverse of its last level, never a lucky match
	always @(dout_i or dout_oe_i) if (dout_oe_i) held = dout_i;
	// serial clock idles low between frames, frame sync idles high
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o = 1'b0;
		fs_o = 1'b1;
		cyc = 0;
	end
	// one SCLK cycle of 400 ns; the line is read just before the next fall
	task automatic tick(input logic d);
		sclk_o = 1'b0;
		cyc++;
		din_o = d;
		#200 sclk_o = 1'b1;
		#200 rx = {rx[126:0], line};
	endtask
	task automatic frame(input logic [7:0] cmd, input int n, input logic dsp);
		cyc = 0;
		rx = '0;
		#13 cs_n_o = 1'b0;
		if (last_pd == 2'h1 || last_pd == 2'h2) #(SETTLE_NS);
		else #400;
		if (dsp) begin
			fs_o = 1'b0;
			#400 fs_o = 1'b1;
			#400;
		end
		for (int i = 0; i < 8; i++) tick(cmd[7 - i]);
		if (cmd[0]) begin
			sclk_o = 1'b0;
			for (int t = 0; t < 20000 && eoc_n_i !== 1'b0; t++) #50;
		end
		for (int i = 8; i < n; i++) tick(1'b0);
		#200 sclk_o = 1'b0;
		#200 cs_n_o = 1'b1;
		last_pd = cmd[2:1];
		#2000;
	endtask
endmodule

// File: dv/test_serial_adc_command_port.sv
bind serial_adc_command_port adc_cmd_props adc_cmd_props_inst (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .dout_o(dout_o),
	.dout_oe_o(dout_oe_o), .eoc_n_o(eoc_n_o), .frame_sync_out_o(frame_sync_out_o),
	.sample_o(sample_o), .analog_on_o(analog_on_o), .osc_on_o(osc_on_o));

module test_serial_adc_command_port import adc_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wsel = 1'b0;
	logic [RESULT_W-1:0] sample = '0;
	logic cs_n, sclk, din, fs_in, dout, dout_oe, eoc_n, fs_out, smp, a_on, r_on, b_on, o_on;
	logic [2:0] chan;
	logic [2:0] smp_ch;
	int failures = 0;
	int tests_run = 0;
	int seed = 32'h5e25;
	int fs_cnt = 0;
	int smp_cyc = 0;
	int smp_n = 0;
	logic [2:0] smp_list [16];
	always #25 ref_clk_i = ~ref_clk_i;
	serial_adc_command_port #(.OSC_DIV(4)) serial_adc_command_port_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
		.frame_sync_in_i(fs_in), .word_width_select_i(wsel), .sample_data_i(sample),
		.dout_o(dout), .dout_oe_o(dout_oe), .eoc_n_o(eoc_n), .frame_sync_out_o(fs_out),
		.channel_o(chan), .sample_o(smp), .analog_on_o(a_on), .ref_on_o(r_on),
		.buf_on_o(b_on), .osc_on_o(o_on));
	// settle wait shortened so a run stays short
	host_port_model #(.SETTLE_NS(3000)) host_port_model_inst (.dout_i(dout),
		.dout_oe_i(dout_oe), .eoc_n_i(eoc_n), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din),
		.fs_o(fs_in));
	// note frame-sync pulses and where in the frame the hold instant falls
	always @(posedge ref_clk_i) begin
		if (fs_out === 1'b1) fs_cnt++;
		if (smp === 1'b1) smp_cyc = host_port_model_inst.cyc;
		if (smp === 1'b1) smp_ch = chan;
		if (smp === 1'b1 && smp_n < 16) smp_list[smp_n] = chan;
		if (smp === 1'b1) smp_n++;
	end
	function automatic logic [15:0] word(input logic [RESULT_W-1:0] s);
		return {s, 2'b00};
	endfunction
	// deselected power: {reference, buffer}
	function automatic logic [1:0] pwr(input logic [1:0] m);
		return {m == PD_ALL_ON || m == PD_REF_ONLY, m == PD_ALL_ON};
	endfunction
	// input converted by the j-th conversion of an internally clocked scan
	function automatic logic [2:0] scan_ch(input logic [7:0] c, input int j);
		if (c[SCAN_HI:SCAN_LO] == SCAN_LOW) return 3'(j);
		if (c[SCAN_HI:SCAN_LO] == SCAN_UPPER && c[CH_HI:CH_LO] >= 3'h4) return 3'(4 + j);
		return c[CH_HI:CH_LO];
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// one conversion frame with a fresh random analog value
	task automatic run(input logic [7:0] cmd, input logic w, input logic dsp, input int words);
		logic [15:0] exp;
		@(posedge ref_clk_i);
		#2 wsel = w;
		sample = RESULT_W'($random(seed));
		exp = word(sample);
		fs_cnt = 0;
		smp_cyc = 0;
		smp_n = 0;
		smp_ch = 3'h0;
		host_port_model_inst.frame(cmd, cmd[0] ? 8 + 16 * words : (w ? 32 : 24), dsp);
		for (int i = 0; i < words; i++) begin
			check(host_port_model_inst.rx[16 * i +: 16], exp, "result word");
		end
		if (!cmd[0]) begin
			check(smp_cyc, w ? 15 : 7, "hold instant");
			check(smp_ch, cmd[7:5], "channel");
			check(fs_cnt, dsp, "frame sync pulses");
		end else begin
			// the first hold pulse is the speculative one at the 6th fall
			check(smp_n, words + 1, "hold pulses");
			for (int j = 0; j < words; j++) begin
				check(smp_list[j + 1], scan_ch(cmd, j), "scan channel");
			end
		end
		check({a_on, r_on, b_on, o_on, dout_oe}, {1'b0, pwr(cmd[2:1]), 2'h0}, "idle");
	endtask
	// hang guard, far beyond the expected run length
	initial begin
		#3000000;
		failures++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge ref_clk_i);
		#2 rst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		check({chan, a_on, r_on, b_on, o_on, eoc_n, dout_oe}, 32'h2, "reset state");
		// external clock: every power code, random width, last four in frame-sync mode
		for (int k = 0; k < 12; k++) begin
			run({3'($random(seed)), SCAN_SINGLE, 2'(k), 1'b0}, 1'($random(seed)), k > 7, 1);
		end
		// internal clock: single, then each scan code
		run({3'($random(seed)), SCAN_SINGLE, PD_ALL_ON, 1'b1}, 1'b0, 1'b0, 1);
		run({3'h2, SCAN_LOW, PD_EXT_REF, 1'b1}, 1'b0, 1'b0, 3);
		run({3'h5, SCAN_UPPER, PD_EXT_REF, 1'b1}, 1'b0, 1'b0, 2);
		run({3'($random(seed)), SCAN_REPEAT, PD_ALL_OFF, 1'b1}, 1'b0, 1'b0, 8);
		final_report();
	end
endmodule
